// >>> design/rfl_params.svh
`ifndef RFL_PARAMS_SVH
`define RFL_PARAMS_SVH

// register addresses on the host register port
`define RFL_ADDR_W 5
`define RFL_ADDR_FIFO_STAT 5'h1c
`define RFL_ADDR_TX_UPPER 5'h1d
`define RFL_ADDR_TX_LOWER 5'h1e

// reset and clear value of the length registers, and idle value of the read port
`define RFL_LEN_RESET 8'h00
`define RFL_RD_IDLE 8'h00

// status register layout
`define RFL_STAT_OVF_BIT 7
`define RFL_CNT_W 7

// lower length register layout
`define RFL_LO_CNT_MSB 7
`define RFL_LO_CNT_LSB 4
`define RFL_LO_BITS_MSB 3
`define RFL_LO_BITS_LSB 1
`define RFL_LO_FLAG_BIT 0

// storage sizes
`define RFL_DATA_W 8
`define RFL_STORE_DEPTH 127
`define RFL_STORE_LAST 7'h7e
`define RFL_STORE_FULL 7'h7f
`define RFL_STAGE_DEPTH 16

`endif

// >>> design/rfl_pkg.sv
package rfl_pkg;
  typedef logic [7:0] rfl_byte_t;
  typedef logic [6:0] rfl_cnt_t;
  typedef logic [11:0] rfl_len_t;
  typedef logic [2:0] rfl_bits_t;
endpackage : rfl_pkg

// >>> design/rfl_fifo.sv
`timescale 1ns/1ps
module rfl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // occupancy
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [LW-1:0] FULL = LW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [LW-1:0] lvl_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (lvl_q != FULL);
  assign out_valid = (lvl_q != '0);
  assign out_data = mem_q[rp_q];
  assign level = lvl_q;

  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      lvl_q <= '0;
    end else if (clk_en) begin
      if (flush) begin
        wp_q <= '0;
        rp_q <= '0;
        lvl_q <= '0;
      end else begin
        if (push) wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
        if (pop) rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
        lvl_q <= lvl_q + LW'(push) - LW'(pop);
      end
    end
  end
endmodule : rfl_fifo

// >>> design/rfl_fifo_status.sv
`timescale 1ns/1ps
`include "rfl_params.svh"

module rfl_fifo_status
  import rfl_pkg::*;
(
  // clock, reset, clock enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // chip enable pin, asynchronous
  input wire logic chip_en,
  // host register port
  input wire logic [`RFL_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // host data into the fifo
  input wire logic host_wr_valid,
  output logic host_wr_ready,
  input wire logic [7:0] host_wr_data,
  // encoder side draining the fifo
  output logic enc_rd_valid,
  input wire logic enc_rd_ready,
  output logic [7:0] enc_rd_data,
  // frame events from the framer
  input wire logic fifo_flush,
  input wire logic tx_eof,
  // transmit length to the framer
  output logic [11:0] tx_count,
  output logic tx_partial,
  output logic [2:0] tx_partial_bits
);

  function automatic rfl_cnt_t wrap_inc(input rfl_cnt_t p);
    wrap_inc = (p == `RFL_STORE_LAST) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  // enable pin synchroniser
  logic en_meta_q;
  logic en_sync_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
    end else if (clk_en) begin
      en_meta_q <= chip_en;
      en_sync_q <= en_meta_q;
    end
  end

  // staging fifo in front of the main store
  logic stg_valid;
  logic stg_ready;
  logic stg_in_ready;
  rfl_byte_t stg_data;
  logic [$clog2(`RFL_STAGE_DEPTH+1)-1:0] stg_level;
  wire clr_all = fifo_flush || !en_sync_q;

  // main store; flops, not a macro; only the pointers and count clear, the data is kept
  rfl_byte_t store_q [`RFL_STORE_DEPTH];
  rfl_cnt_t wp_q;
  rfl_cnt_t rp_q;
  rfl_cnt_t sc_q;
  rfl_cnt_t sc_d;
  logic ovf_q;
  logic ovf_d;

  wire [7:0] total = 8'(sc_q) + 8'(stg_level);
  wire total_full = (total >= 8'(`RFL_STORE_FULL));
  wire mv = stg_valid && stg_ready;
  wire pop = enc_rd_valid && enc_rd_ready;
  // bytes refused at the door count as presented beyond the limit
  wire ovf_set = host_wr_valid && total_full;

  assign host_wr_ready = stg_in_ready && !total_full;
  assign stg_ready = (sc_q != `RFL_STORE_FULL);
  assign enc_rd_valid = (sc_q != '0);
  assign enc_rd_data = store_q[rp_q];
  assign sc_d = sc_q + rfl_cnt_t'(mv) - rfl_cnt_t'(pop);
  // set wins over a clear in the same cycle
  assign ovf_d = ovf_set || (ovf_q && !clr_all);

  rfl_fifo #(
    .WIDTH(`RFL_DATA_W),
    .DEPTH(`RFL_STAGE_DEPTH)
  ) u_stage (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .flush(clr_all),
    .in_valid(host_wr_valid && !total_full),
    .in_ready(stg_in_ready),
    .in_data(host_wr_data),
    .out_valid(stg_valid),
    .out_ready(stg_ready),
    .out_data(stg_data),
    .level(stg_level)
  );

  always_ff @(posedge sys_clk) begin
    if (clk_en && mv) begin
      store_q[wp_q] <= stg_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      sc_q <= '0;
      ovf_q <= 1'b0;
    end else if (clk_en) begin
      ovf_q <= ovf_d;
      if (clr_all) begin
        wp_q <= '0;
        rp_q <= '0;
        sc_q <= '0;
      end else begin
        if (mv) wp_q <= wrap_inc(wp_q);
        if (pop) rp_q <= wrap_inc(rp_q);
        sc_q <= sc_d;
      end
    end
  end

  // status byte: overflow on top, waiting bytes below
  wire [`RFL_CNT_W-1:0] fill_count = total[`RFL_CNT_W-1:0];
  wire [7:0] stat_byte = {ovf_q, fill_count};

  // length registers
  logic [7:0] tx_hi_q;
  logic [7:0] tx_lo_q;
  logic [7:0] tx_hi_d;
  logic [7:0] tx_lo_d;
  rfl_bits_t tx_bits_q;
  // status has no write path, so a stray host write there is harmless
  wire wr_hi = reg_wr && (reg_addr == `RFL_ADDR_TX_UPPER);
  wire wr_lo = reg_wr && (reg_addr == `RFL_ADDR_TX_LOWER);
  // end of frame and disable beat a host write in the same cycle
  wire len_clr = tx_eof || !en_sync_q;

  assign tx_hi_d = len_clr ? `RFL_LEN_RESET : (wr_hi ? reg_wdata : tx_hi_q);
  assign tx_lo_d = len_clr ? `RFL_LEN_RESET : (wr_lo ? reg_wdata : tx_lo_q);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_hi_q <= `RFL_LEN_RESET;
      tx_lo_q <= `RFL_LEN_RESET;
      tx_bits_q <= '0;
    end else if (clk_en) begin
      tx_hi_q <= tx_hi_d;
      tx_lo_q <= tx_lo_d;
      tx_bits_q <= tx_lo_d[`RFL_LO_FLAG_BIT] ?
          tx_lo_d[`RFL_LO_BITS_MSB:`RFL_LO_BITS_LSB] : '0;
    end
  end

  assign tx_count = {tx_hi_q, tx_lo_q[`RFL_LO_CNT_MSB:`RFL_LO_CNT_LSB]};
  assign tx_partial = tx_lo_q[`RFL_LO_FLAG_BIT];
  assign tx_partial_bits = tx_bits_q;

  // register read port, one cycle latency
  wire sel_stat = (reg_addr == `RFL_ADDR_FIFO_STAT);
  wire sel_hi = (reg_addr == `RFL_ADDR_TX_UPPER);
  wire sel_lo = (reg_addr == `RFL_ADDR_TX_LOWER);
  wire [7:0] rd_mux = sel_stat ? stat_byte :
                      sel_hi ? tx_hi_q :
                      sel_lo ? tx_lo_q : `RFL_RD_IDLE;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `RFL_RD_IDLE;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_ovf_sticky_set: assert property (
    clk_en && host_wr_valid && total_full |=> ovf_q && stat_byte[7])
    else $error("overflow not flagged on byte beyond limit");

  a_fill_limit_ready: assert property (
    total >= 8'(`RFL_STORE_FULL) |->
      !host_wr_ready && total == 8'(`RFL_STORE_FULL))
    else $error("fifo accepts past 127 bytes");

  a_stat_read_back: assert property (
    clk_en && reg_rd && sel_stat |=> reg_rdata == $past(stat_byte))
    else $error("status read differs from fill state");

  a_pop_count_drop: assert property (
    clk_en && pop && !mv && !clr_all |=> sc_q == $past(sc_q) - 7'd1)
    else $error("store count not decremented on read");

  a_upper_write: assert property (
    clk_en && wr_hi && !len_clr |=> tx_count[11:4] == $past(reg_wdata))
    else $error("upper count bits not taken from write");

  a_lower_write: assert property (
    clk_en && wr_lo && !len_clr |=>
      tx_count[3:0] == $past(reg_wdata[7:4]) &&
      tx_partial == $past(reg_wdata[0]))
    else $error("lower count or flag not taken from write");

  a_eof_clears_len: assert property (
    clk_en && len_clr |=> tx_count == 12'h000 && !tx_partial
      && tx_lo_q == 8'h00 && tx_hi_q == 8'h00)
    else $error("length registers not cleared");

  a_bits_when_flag: assert property (
    clk_en && wr_lo && !len_clr && reg_wdata[0] |=>
      tx_partial_bits == $past(reg_wdata[3:1]))
    else $error("partial bit count not passed on");

  a_bits_ignored: assert property (
    !tx_partial |-> tx_partial_bits == 3'h0)
    else $error("partial bit count used without flag");

  c_overflow_seen: cover property (ovf_q);
  c_store_full: cover property (sc_q == `RFL_STORE_FULL);
  c_eof_clear: cover property (clk_en && tx_eof && tx_count != 12'h000);
  c_partial_set: cover property (tx_partial && tx_partial_bits != 3'h0);

endmodule : rfl_fifo_status

// >>> dv/rfl_drain_model.sv
`timescale 1ns/1ps
module rfl_drain_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // consumer pacing
  input wire logic stall,
  input wire logic slow,
  // encoder side
  input wire logic enc_rd_valid,
  output logic enc_rd_ready
);
  logic phase_q;
  // slow mode takes a byte only every other cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) phase_q <= 1'b0;
    else phase_q <= ~phase_q;
  end
  assign enc_rd_ready = !stall && (!slow || phase_q);
endmodule : rfl_drain_model

// >>> dv/rfl_fifo_status_tb.sv
`timescale 1ns/1ps
`include "rfl_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module rfl_fifo_status_tb;
  logic sys_clk = 0, resetn = 0, clk_en = 1, chip_en = 1;
  logic [4:0] reg_addr = 0;
  logic reg_wr = 0, reg_rd = 0, host_wr_valid = 0;
  logic fifo_flush = 0, tx_eof = 0, stall = 1, slow = 0;
  logic [7:0] reg_wdata = 0, host_wr_data = 0, reg_rdata, enc_rd_data, v;
  logic host_wr_ready, enc_rd_valid, enc_rd_ready, tx_partial;
  logic [11:0] tx_count;
  logic [2:0] tx_partial_bits;
  int error_cnt = 0, check_count = 0, n;
  rfl_fifo_status rfl_fifo_status_i (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .chip_en(chip_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .host_wr_valid(host_wr_valid),
    .host_wr_ready(host_wr_ready), .host_wr_data(host_wr_data),
    .enc_rd_valid(enc_rd_valid), .enc_rd_ready(enc_rd_ready),
    .enc_rd_data(enc_rd_data), .fifo_flush(fifo_flush), .tx_eof(tx_eof),
    .tx_count(tx_count), .tx_partial(tx_partial),
    .tx_partial_bits(tx_partial_bits));
  rfl_drain_model rfl_drain_model_i (.sys_clk(sys_clk), .resetn(resetn),
    .stall(stall), .slow(slow), .enc_rd_valid(enc_rd_valid),
    .enc_rd_ready(enc_rd_ready));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task close_out();
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge sys_clk);
    reg_wr = 0;
    @(negedge sys_clk);
  endtask : wr
  task rd(input logic [4:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1;
    @(negedge sys_clk);
    reg_rd = 0;
    d = reg_rdata;
    @(negedge sys_clk);
  endtask : rd
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge sys_clk);
    s = 0;
    @(negedge sys_clk);
  endtask : pulse
  task push(input logic [7:0] d);
    int i;
    host_wr_valid = 1;
    host_wr_data = d;
    for (i = 0; i < 50 && host_wr_ready !== 1'b1; i++) @(negedge sys_clk);
    if (i == 50) begin
      error_cnt++;
      close_out();
    end
    @(negedge sys_clk);
  endtask : push
  task t_reset();
    rd(5'h1d, v); `CHK(v, 8'h00)
    rd(5'h1e, v); `CHK(v, 8'h00)
    rd(5'h1c, v); `CHK(v, 8'h00)
    rd(5'h1f, v); `CHK(v, 8'h00)
  endtask : t_reset
  task t_len();
    wr(5'h1d, 8'hab);
    wr(5'h1e, 8'h5b);
    `CHK(tx_count, 12'hab5)
    `CHK(tx_partial, 1'b1)
    `CHK(tx_partial_bits, 3'h5)
    rd(5'h1d, v); `CHK(v, 8'hab)
    rd(5'h1e, v); `CHK(v, 8'h5b)
    wr(5'h1e, 8'h5a);
    `CHK(tx_partial, 1'b0)
    `CHK(tx_partial_bits, 3'h0)
    wr(5'h1c, 8'hff);
    rd(5'h1c, v); `CHK(v, 8'h00)
    pulse(tx_eof);
    `CHK(tx_count, 12'h000)
    rd(5'h1e, v); `CHK(v, 8'h00)
  endtask : t_len
  task t_fill();
    stall = 1;
    for (n = 0; n < 127; n++) push(n[7:0]);
    @(negedge sys_clk);
    `CHK(host_wr_ready, 1'b0)
    host_wr_valid = 0;
    rd(5'h1c, v); `CHK(v, 8'hff)
    stall = 0;
    slow = 1;
    n = 0;
    for (int i = 0; i < 600 && n < 127; i++) begin
      if (enc_rd_valid === 1'b1 && enc_rd_ready === 1'b1) begin
        `CHK(enc_rd_data, n[7:0])
        n++;
      end
      @(negedge sys_clk);
    end
    `CHK(n, 127)
    rd(5'h1c, v); `CHK(v, 8'h80)
    pulse(fifo_flush);
    rd(5'h1c, v); `CHK(v, 8'h00)
  endtask : t_fill
  task t_en();
    stall = 1;
    wr(5'h1d, 8'h3c);
    `CHK(tx_count, 12'h3c0)
    push(8'h77);
    host_wr_valid = 0;
    rd(5'h1c, v); `CHK(v, 8'h01)
    chip_en = 0;
    repeat (4) @(negedge sys_clk);
    `CHK(tx_count, 12'h000)
    chip_en = 1;
    repeat (4) @(negedge sys_clk);
    rd(5'h1d, v); `CHK(v, 8'h00)
    rd(5'h1c, v); `CHK(v, 8'h00)
  endtask : t_en
  // clock enable low must freeze writes and end-of-frame clears
  task t_freeze();
    wr(5'h1d, 8'h12);
    clk_en = 0;
    wr(5'h1d, 8'h34);
    pulse(tx_eof);
    `CHK(tx_count, 12'h120)
    clk_en = 1;
    rd(5'h1d, v); `CHK(v, 8'h12)
  endtask : t_freeze
  initial begin
    #2500000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    resetn = 1;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_len();
    t_fill();
    t_en();
    t_freeze();
    close_out();
  end
endmodule : rfl_fifo_status_tb
